// ### pkg/psbs_pkg.sv
package psbs_pkg;

  // ==========================================================
  // Timing and width constants
  // ==========================================================
  localparam int PSBS_CLK_MHZ = 50;
  localparam int PSBS_DELAY_W = 8;
  localparam int PSBS_PERIOD_W = 12;
  localparam logic [7:0] PSBS_DELAY_RST = 8'h04;
  localparam logic [7:0] PSBS_MIN_DELAY = 8'h01;

  // ==========================================================
  // Bridge drive bundle
  // ==========================================================
  typedef struct packed {
    logic left_high;
    logic left_low;
    logic right_high;
    logic right_low;
    logic rect_one;
    logic rect_two;
  } psbs_drive_type;

  localparam psbs_drive_type PSBS_DRIVE_OFF = '0;

  // ==========================================================
  // Sequencer states, one-hot
  // ==========================================================
  typedef enum logic [6:0] {
    PSBS_IDLE     = 7'h01,
    PSBS_LEFT_DT  = 7'h02,
    PSBS_POWER    = 7'h04,
    PSBS_RIGHT_DT = 7'h08,
    PSBS_FREE     = 7'h10,
    PSBS_END_DT   = 7'h20,
    PSBS_STOP     = 7'h40
  } psbs_state_type;

endpackage

// ### design/psbs_delay_timer.sv
`timescale 1ns/10ps
// ============================================================
// Dead-time counter: loads on start, pulses done when expired
// ============================================================
module psbs_delay_timer
  import psbs_pkg::*;
#(
  parameter int WIDTH = PSBS_DELAY_W
) (
  input wire logic clock_in, // System clock
  input wire logic rstn_in, // Sync reset, active low
  input wire logic enable_in, // Clock enable
  input wire logic start_in, // Load count
  input wire logic [WIDTH-1:0] count_in, // Cycles to wait
  output logic done_out // One-cycle expiry pulse
);

  initial begin
    if (WIDTH < 2) $error("psbs_delay_timer: WIDTH too small");
  end

  logic [WIDTH-1:0] remain;
  logic running;
  wire last_tick = running && (remain <= WIDTH'(1));

  // Count down; a zero load still waits one cycle
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      remain <= '0;
      running <= 1'b0;
      done_out <= 1'b0;
    end else if (enable_in) begin
      done_out <= last_tick && !start_in;
      if (start_in) begin
        remain <= count_in;
        running <= 1'b1;
      end else if (last_tick) begin
        running <= 1'b0;
      end else if (running) begin
        remain <= remain - WIDTH'(1);
      end
    end
  end

endmodule

// ### design/psbs_oscillator.sv
`timescale 1ns/10ps
// ============================================================
// Cycle oscillator: pulses at end of each switching cycle
// ============================================================
module psbs_oscillator
  import psbs_pkg::*;
#(
  parameter int WIDTH = PSBS_PERIOD_W
) (
  input wire logic clock_in, // System clock
  input wire logic rstn_in, // Sync reset, active low
  input wire logic enable_in, // Clock enable
  input wire logic run_in, // Oscillator runs when high
  input wire logic [WIDTH-1:0] period_in, // Cycle length in clocks
  output logic cycle_end_out // One-cycle pulse at cycle end
);

  initial begin
    if (WIDTH < 4) $error("psbs_oscillator: WIDTH too small");
  end

  logic [WIDTH-1:0] count;
  wire wrap = (count + WIDTH'(1)) >= period_in;

  // Free count, restarted whenever not running
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      count <= '0;
      cycle_end_out <= 1'b0;
    end else if (enable_in) begin
      if (!run_in) begin
        count <= '0;
        cycle_end_out <= 1'b0;
      end else begin
        count <= wrap ? '0 : count + WIDTH'(1);
        cycle_end_out <= wrap;
      end
    end
  end

endmodule

// ### design/psbs_sequencer.sv
`timescale 1ns/10ps
// Behaviour
// - Power transfer drives exactly one diagonal pair
// - Left-high phase: PWM ends by dropping right-low
// - Programmable dead-time before right-high turns on
// - Freewheel: both highs or both lows alternately
// - Both rectifiers on during primary freewheel
// - Cycle end drops left-high and rectifier one
// - Left-low plus right-high starts next transfer
// - Opposite phase: PWM ends by dropping right-high
// - Then right-low on, both lows freewheel
// - Right leg turns off only from PWM, cycle end at max duty, a stop or run going low
// - Left leg turns off only from cycle end or hard stop
// - Current mode ends transfer at current peak
// - Hard stop forces all gate outputs low immediately
module psbs_sequencer
  import psbs_pkg::*;
#(
  parameter int DELAY_W = PSBS_DELAY_W,
  parameter int PERIOD_W = PSBS_PERIOD_W,
  parameter int SENSE_W = 10
) (
  input wire logic clock_in, // 50 MHz system clock
  input wire logic rstn_in, // Sync reset, active low
  input wire logic enable_in, // Clock enable, freezes all state
  input wire logic run_in, // Converter enabled
  input wire logic current_mode_in, // 1 current mode, 0 voltage mode
  input wire logic [SENSE_W-1:0] sense_in, // Current or ramp sample
  input wire logic [SENSE_W-1:0] error_in, // Error amplifier level
  input wire logic [PERIOD_W-1:0] period_in, // Cycle length, clocks
  input wire logic [DELAY_W-1:0] left_leg_delay_set_in, // Left dead-time
  input wire logic [DELAY_W-1:0] right_leg_delay_set_in, // Right dead-time
  input wire logic hard_stop_select_in, // Stop hard on any fault
  input wire logic fault_in, // Fault level
  input wire logic hard_fault_in, // Fault that always stops hard
  output logic left_high_drive_out, // Left high-side gate
  output logic left_low_drive_out, // Left low-side gate
  output logic right_high_drive_out, // Right high-side gate
  output logic right_low_drive_out, // Right low-side gate
  output logic rectifier_one_drive_out, // First rectifier gate
  output logic rectifier_two_drive_out, // Second rectifier gate
  output logic phase_out, // 0 left-high phase, 1 left-low phase
  output logic stopped_out // Outputs held off by stop
);

  initial begin
    if (DELAY_W < 2 || DELAY_W > 16) $error("psbs_sequencer: DELAY_W");
    if (PERIOD_W < 4) $error("psbs_sequencer: PERIOD_W");
    if (SENSE_W < 1) $error("psbs_sequencer: SENSE_W");
  end

  // ==========================================================
  // State
  // ==========================================================
  psbs_state_type state;
  psbs_state_type next_state;
  psbs_drive_type drive;
  psbs_drive_type next_drive;
  logic phase;
  logic next_phase;
  logic blank;
  logic next_blank;

  wire cycle_end;
  wire delay_done;
  logic delay_start;
  logic [DELAY_W-1:0] delay_count;

  // ==========================================================
  // Decisions
  // ==========================================================
  // Comparator is shared by both modes; in current mode the sense
  // input carries the primary current, so each phase ends at the
  // same peak, which balances transformer flux
  function automatic logic psbs_reached(
    input logic [SENSE_W-1:0] level,
    input logic [SENSE_W-1:0] limit
  );
    psbs_reached = level >= limit;
  endfunction

  // Voltage mode still uses the ramp compare; mode only documents
  // what the sense input carries, so the decision is identical
  wire pwm_end = !blank && psbs_reached(sense_in, error_in);
  wire stop_now = hard_fault_in || (fault_in && hard_stop_select_in);
  wire soft_stop = fault_in && !hard_stop_select_in;
  wire go = run_in && !fault_in && !hard_fault_in;
  wire unused_mode = current_mode_in;
  // Oscillator keeps running through a soft stop so the cycle can end
  wire osc_run = (go || state != PSBS_IDLE) && state != PSBS_STOP;

  // ==========================================================
  // Helpers
  // ==========================================================
  psbs_oscillator #(
    .WIDTH(PERIOD_W)
  ) u_osc (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .enable_in(enable_in),
    .run_in(osc_run),
    .period_in(period_in),
    .cycle_end_out(cycle_end)
  );

  psbs_delay_timer #(
    .WIDTH(DELAY_W)
  ) u_delay (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .enable_in(enable_in),
    .start_in(delay_start),
    .count_in(delay_count),
    .done_out(delay_done)
  );

  // ==========================================================
  // Sequencing
  // ==========================================================
  // Each cycle: left dead-time, diagonal power, right dead-time,
  // freewheel, then the cycle end drops the conducting left switch
  always_comb begin
    next_state = state;
    next_drive = drive;
    next_phase = phase;
    next_blank = 1'b0;
    delay_start = 1'b0;
    delay_count = left_leg_delay_set_in;
    case (state)
      PSBS_IDLE: begin
        next_drive = PSBS_DRIVE_OFF;
        if (go) begin
          next_state = PSBS_LEFT_DT;
          next_phase = 1'b0;
          delay_start = 1'b1;
        end
      end
      PSBS_LEFT_DT: begin
        if (delay_done) begin
          next_state = PSBS_POWER;
          next_blank = 1'b1;
          // Left switch closes the diagonal with the right one
          next_drive.left_high = !phase;
          next_drive.left_low = phase;
          next_drive.right_low = !phase;
          next_drive.right_high = phase;
          next_drive.rect_one = !phase;
          next_drive.rect_two = phase;
        end
      end
      PSBS_POWER: begin
        if (pwm_end) begin
          // Right leg turns off here, or at max duty in the branch below
          next_drive.right_low = 1'b0;
          next_drive.right_high = 1'b0;
          next_state = PSBS_RIGHT_DT;
          delay_start = 1'b1;
          delay_count = right_leg_delay_set_in;
        end else if (cycle_end) begin
          // Max duty reached; still end via the right leg first
          next_drive.right_low = 1'b0;
          next_drive.right_high = 1'b0;
          next_state = PSBS_RIGHT_DT;
          delay_start = 1'b1;
          delay_count = right_leg_delay_set_in;
        end
      end
      PSBS_RIGHT_DT: begin
        if (delay_done) begin
          // Complementary right switch on: freewheel on same rail
          next_drive.right_high = !phase;
          next_drive.right_low = phase;
          next_drive.rect_one = 1'b1;
          next_drive.rect_two = 1'b1;
          next_state = PSBS_FREE;
        end
      end
      PSBS_FREE: begin
        if (cycle_end) begin
          // Left leg turns off here, or at a hard stop, with rectifier one in phase 0, rectifier two in phase 1
          next_drive.left_high = 1'b0;
          next_drive.left_low = 1'b0;
          next_drive.rect_one = phase;
          next_drive.rect_two = !phase;
          next_phase = !phase;
          next_state = PSBS_END_DT;
          delay_start = 1'b1;
        end
      end
      PSBS_END_DT: begin
        if (soft_stop || !run_in) begin
          next_state = PSBS_IDLE;
          next_drive = PSBS_DRIVE_OFF;
        end else begin
          next_state = PSBS_LEFT_DT;
        end
      end
      PSBS_STOP: begin
        next_drive = PSBS_DRIVE_OFF;
        if (!stop_now && !fault_in) begin
          next_state = PSBS_IDLE;
        end
      end
      default: begin
        next_state = PSBS_STOP;
        next_drive = PSBS_DRIVE_OFF;
      end
    endcase
    // Hard stop overrides everything in the same clock
    if (stop_now) begin
      next_state = PSBS_STOP;
      next_drive = PSBS_DRIVE_OFF;
    end else if (!go && state != PSBS_END_DT && state != PSBS_STOP) begin
      // Soft stop waits for the cycle to end cleanly
      if (state == PSBS_IDLE || state == PSBS_LEFT_DT) begin
        next_state = PSBS_IDLE;
        next_drive = PSBS_DRIVE_OFF;
      end
    end
    // Leg interlock as last safety net
    if (next_drive.left_high && next_drive.left_low) begin
      next_drive.left_high = 1'b0;
      next_drive.left_low = 1'b0;
    end
    if (next_drive.right_high && next_drive.right_low) begin
      next_drive.right_high = 1'b0;
      next_drive.right_low = 1'b0;
    end
  end

  // Flags END_DT exit to LEFT_DT; the left dead-time timer is not reloaded here
  wire end_dt_restart = (state == PSBS_END_DT) && !stop_now && go;

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state <= PSBS_IDLE;
      drive <= PSBS_DRIVE_OFF;
      phase <= 1'b0;
      blank <= 1'b0;
    end else if (enable_in) begin
      state <= next_state;
      drive <= next_drive;
      phase <= next_phase;
      blank <= next_blank;
    end
  end

  // Output flops; stop flag mirrors the stop state
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      left_high_drive_out <= 1'b0;
      left_low_drive_out <= 1'b0;
      right_high_drive_out <= 1'b0;
      right_low_drive_out <= 1'b0;
      rectifier_one_drive_out <= 1'b0;
      rectifier_two_drive_out <= 1'b0;
      phase_out <= 1'b0;
      stopped_out <= 1'b0;
    end else if (enable_in) begin
      left_high_drive_out <= next_drive.left_high;
      left_low_drive_out <= next_drive.left_low;
      right_high_drive_out <= next_drive.right_high;
      right_low_drive_out <= next_drive.right_low;
      rectifier_one_drive_out <= next_drive.rect_one;
      rectifier_two_drive_out <= next_drive.rect_two;
      phase_out <= next_phase;
      stopped_out <= (next_state == PSBS_STOP);
    end
  end

  // Timer restart for the left dead-time after cycle end is
  // already issued from FREE; this flag is left unused
  wire unused_restart = end_dt_restart;

endmodule

// ### tb/psbs_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// Gate sequence checker
// ==========================================================
module psbs_monitor (
  input wire logic clock_in, // System clock
  input wire logic rstn_in, // Sync reset, active low
  input wire logic run_in, // Converter on
  input wire logic enable_in, // Clock enable
  input wire logic hard_fault_in, // Hard fault
  input wire logic left_high_drive_out, // Gate
  input wire logic left_low_drive_out, // Gate
  input wire logic right_high_drive_out, // Gate
  input wire logic right_low_drive_out, // Gate
  input wire logic rectifier_one_drive_out, // Gate
  input wire logic rectifier_two_drive_out, // Gate
  input wire logic phase_out, // Phase
  input wire logic stopped_out // Stop flag
);
  wire logic lh, ll, rh, rl, ro, rt, off;
  // Short aliases keep the properties readable
  assign lh = left_high_drive_out;
  assign ll = left_low_drive_out;
  assign rh = right_high_drive_out;
  assign rl = right_low_drive_out;
  assign ro = rectifier_one_drive_out;
  assign rt = rectifier_two_drive_out;
  assign off = !(lh || ll || rh || rl || ro || rt);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // Turn-off events not caused by a stop
  sequence lh_drop; $fell(lh) && !stopped_out; endsequence
  sequence ll_drop; $fell(ll) && !stopped_out; endsequence
  sequence rl_drop; $fell(rl) && !stopped_out; endsequence
  sequence rh_drop; $fell(rh) && !stopped_out; endsequence
  leg_exclusive_a: assert property (!(lh && ll) && !(rh && rl))
    else $error("leg driven high and low");
  leg_gap_a: assert property (
    !($rose(lh) && $past(ll)) && !($rose(ll) && $past(lh)) &&
    !($rose(rh) && $past(rl)) && !($rose(rl) && $past(rh)))
    else $error("leg switched with no gap");
  diagonal_phase_a: assert property (
    ((lh && rl) |-> !phase_out) and ((ll && rh) |-> phase_out))
    else $error("diagonal in wrong phase");
  free_alt_a: assert property (
    ((lh && rh) |-> !phase_out) and ((ll && rl) |-> phase_out))
    else $error("freewheel pair in wrong phase");
  free_rect_a: assert property (
    (lh && rh) || (ll && rl) |-> ro && rt)
    else $error("rectifiers not both on");
  cycle_end_a: assert property (lh_drop |-> $fell(ro))
    else $error("left high and rectifier one split");
  right_pwm_a: assert property (
    disable iff (!rstn_in || !run_in) rl_drop |-> lh && !phase_out)
    else $error("right low dropped outside transfer");
  opp_pwm_a: assert property (
    disable iff (!rstn_in || !run_in) rh_drop |-> ll && phase_out)
    else $error("right high dropped outside transfer");
  left_clock_a: assert property (
    disable iff (!rstn_in || !run_in) (lh_drop |-> rh) and (ll_drop |-> rl))
    else $error("left leg dropped outside freewheel");
  next_diag_a: assert property (
    disable iff (!rstn_in || !run_in) $rose(ll) |-> rh && phase_out)
    else $error("left low on without right high");
  low_free_a: assert property (
    disable iff (!rstn_in || !run_in) $rose(rl) |-> ll || lh)
    else $error("right low on out of order");
  hard_stop_a: assert property (
    hard_fault_in && enable_in |-> ##[1:2] off && stopped_out)
    else $error("hard fault did not stop outputs");
  stop_quiet_a: assert property (stopped_out |-> off)
    else $error("output on while stopped");
endmodule

bind psbs_sequencer psbs_monitor u_mon (.clock_in(clock_in),
  .rstn_in(rstn_in), .run_in(run_in), .enable_in(enable_in),
  .hard_fault_in(hard_fault_in), .left_high_drive_out(left_high_drive_out),
  .left_low_drive_out(left_low_drive_out),
  .right_high_drive_out(right_high_drive_out),
  .right_low_drive_out(right_low_drive_out),
  .rectifier_one_drive_out(rectifier_one_drive_out),
  .rectifier_two_drive_out(rectifier_two_drive_out),
  .phase_out(phase_out), .stopped_out(stopped_out));

// ### tb/psbs_bridge_model.sv
`timescale 1ns/10ps
// ==========================================================
// External bridge: switch nodes and conflict watch
// ==========================================================
module psbs_bridge_model
  import psbs_pkg::*;
(
  input wire logic clock_in, // System clock
  input wire psbs_drive_type gate_in, // Gate levels
  output logic left_switch_node_out, // Left node level
  output logic right_switch_node_out, // Right node level
  output logic shoot_through_out // Leg conflict seen
);
  initial begin
    left_switch_node_out = 1'b0;
    right_switch_node_out = 1'b0;
    shoot_through_out = 1'b0;
  end
  // A floating node rings, so it never keeps its last level
  always @(posedge clock_in) begin
    if (gate_in.left_high) left_switch_node_out <= 1'b1;
    else if (gate_in.left_low) left_switch_node_out <= 1'b0;
    else left_switch_node_out <= !left_switch_node_out;
    if (gate_in.right_high) right_switch_node_out <= 1'b1;
    else if (gate_in.right_low) right_switch_node_out <= 1'b0;
    else right_switch_node_out <= !right_switch_node_out;
    if ((gate_in.left_high && gate_in.left_low) ||
        (gate_in.right_high && gate_in.right_low)) begin
      shoot_through_out <= 1'b1;
    end
  end
endmodule

// ### tb/psbs_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module psbs_sequencer_tb_top
  import psbs_pkg::*;
;
  logic clock_in = 0, rstn_in = 0, enable_in = 1, run_in = 0, cmode = 0;
  logic [9:0] sense_in = 10'h000, error_in = 10'h0C8;
  logic [11:0] period_in = 12'h03C;
  logic [7:0] ldly = 8'h02, rdly = 8'h03;
  logic sel = 0, fault = 0, hfault = 0;
  logic [31:0] lfsr = 32'h00018679, r;
  wire psbs_drive_type drv;
  psbs_drive_type held;
  wire logic phase, stopped, lnode, rnode, shoot;
  int fails = 0, tests_run = 0, n, k;
  always #10 clock_in = !clock_in;
  psbs_sequencer DUT (.clock_in(clock_in), .rstn_in(rstn_in),
    .enable_in(enable_in), .run_in(run_in), .current_mode_in(cmode),
    .sense_in(sense_in), .error_in(error_in), .period_in(period_in),
    .left_leg_delay_set_in(ldly), .right_leg_delay_set_in(rdly),
    .hard_stop_select_in(sel), .fault_in(fault), .hard_fault_in(hfault),
    .left_high_drive_out(drv.left_high), .left_low_drive_out(drv.left_low),
    .right_high_drive_out(drv.right_high),
    .right_low_drive_out(drv.right_low),
    .rectifier_one_drive_out(drv.rect_one),
    .rectifier_two_drive_out(drv.rect_two),
    .phase_out(phase), .stopped_out(stopped));
  psbs_bridge_model u_bridge (.clock_in(clock_in), .gate_in(drv),
    .left_switch_node_out(lnode), .right_switch_node_out(rnode),
    .shoot_through_out(shoot));
  // Galois shift register, one step per draw
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction
  // A zero dead-time setting still waits one clock
  function automatic int exp_gap(input logic [7:0] d);
    exp_gap = (d == 8'h00) ? 1 : int'(d);
  endfunction
  task final_report;
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(negedge clock_in);
  endtask
  // Bounded wait for a gate pattern; running out ends the run
  task wait_gate(input logic [5:0] m, input logic [5:0] v, input int lim);
    for (n = 0; n < lim && (drv & m) !== v; n++) @(negedge clock_in);
    if (n >= lim) begin
      fails++;
      final_report;
    end
  endtask
  task restart;
    rstn_in = 0;
    tick(2);
    rstn_in = 1;
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    tick(6);
    rstn_in = 1;
    run_in = 1;
    for (k = 0; k < 10; k++) begin
      lfsr = next_rand(lfsr);
      r = lfsr;
      rdly = {5'h00, r[2:0]};
      ldly = {6'h00, r[14:13]};
      cmode = r[3];
      sense_in = 10'h010 + r[8:4];
      wait_gate(6'h3C, k[0] ? 6'h18 : 6'h24, 200);
      `CHK("phase", k[0], phase)
      tick(5);
      `CHK("diagonal held", k[0] ? 6'h18 : 6'h24, drv & 6'h3C)
      `CHK("nodes", {!k[0], k[0]}, {lnode, rnode})
      sense_in = error_in + r[12:9];
      wait_gate(k[0] ? 6'h08 : 6'h04, 6'h00, 4);
      `CHK("left kept", k[0] ? 6'h10 : 6'h20, drv & 6'h30)
      wait_gate(k[0] ? 6'h04 : 6'h08, k[0] ? 6'h04 : 6'h08, 20);
      `CHK("dead time", 1'b1, n >= exp_gap(rdly))
      tick(1);
      `CHK("freewheel", k[0] ? 6'h17 : 6'h2B, drv)
      wait_gate(k[0] ? 6'h10 : 6'h20, 6'h00, 80);
      `CHK("cycle end", k[0] ? 6'h04 : 6'h08, drv & 6'h3C)
      if (!k[0]) `CHK("rect one off", 1'b0, drv.rect_one)
    end
    // Clock enable low must freeze every output
    held = drv;
    enable_in = 0;
    tick(5);
    `CHK("frozen", held, drv)
    enable_in = 1;
    tick(7);
    hfault = 1;
    tick(3);
    `CHK("hard stop", 7'h40, {stopped, drv})
    hfault = 0;
    restart;
    sel = 1;
    tick(30);
    fault = 1;
    tick(3);
    `CHK("selected stop", 7'h40, {stopped, drv})
    fault = 0;
    sel = 0;
    restart;
    tick(25);
    run_in = 0;
    wait_gate(6'h3F, 6'h00, 200);
    `CHK("no conflict", 1'b0, shoot)
    final_report;
  end
endmodule
